// ---- rtl/crisl_pkg.sv ----
// Shared constants and types for the processor reset state loader.
package crisl_pkg;
  // Register byte offsets on the APB port.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_LDT_SELLIM = 8'h08;
  localparam logic [7:0] OFF_LDT_BASE = 8'h0c;
  localparam logic [7:0] OFF_TASK_SELLIM = 8'h10;
  localparam logic [7:0] OFF_TASK_BASE = 8'h14;
  localparam logic [7:0] OFF_DESC_ATTR = 8'h18;
  localparam logic [7:0] OFF_CYCLE_COUNT = 8'h1c;
  localparam logic [7:0] OFF_PERF_COUNT = 8'h20;
  localparam logic [7:0] OFF_PERF_SEL = 8'h24;
  localparam logic [7:0] OFF_MTRR_CTRL = 8'h28;
  localparam logic [7:0] OFF_LIC_CTRL = 8'h2c;
  localparam logic [7:0] OFF_MSR_SCRATCH = 8'h30;
  localparam logic [7:0] OFF_MCHK = 8'h34;
  localparam logic [7:0] OFF_FLAGS = 8'h38;
  localparam logic [7:0] OFF_CTRL0 = 8'h3c;
  localparam logic [7:0] OFF_ACCUM = 8'h40;
  localparam logic [7:0] OFF_IDENT = 8'h44;
  localparam logic [7:0] OFF_CS_SEL = 8'h48;
  localparam logic [7:0] OFF_CS_BASE = 8'h4c;
  localparam logic [7:0] OFF_IP = 8'h50;
  localparam logic [7:0] OFF_FETCH = 8'h54;
  localparam logic [7:0] OFF_FPU_CWSW = 8'h58;
  localparam logic [7:0] OFF_FPU_TAG = 8'h5c;
  localparam logic [7:0] OFF_PACKED = 8'h60;
  localparam logic [7:0] OFF_CACHE_VALID = 8'h64;
  localparam logic [7:0] OFF_CACHE_FILL = 8'h68;
  // Control register bit positions.
  localparam int CTRL_SOFT_INIT = 0;
  localparam int CTRL_HARD_RESET = 1;
  localparam int CTRL_FP_INIT = 2;
  // Descriptor reset values.
  localparam logic [15:0] DESC_SEL_RST = 16'h0000;
  localparam logic [31:0] DESC_BASE_RST = 32'h0000_0000;
  localparam logic [15:0] DESC_LIMIT_RST = 16'hffff;
  localparam logic [7:0] DESC_ATTR_RST = 8'h82;
  // Control, flag and fetch values.
  localparam logic [31:0] CTRL0_PWR_RST = 32'h6000_0010;
  localparam logic [31:0] CTRL0_KEEP_MASK = 32'h6000_0000;
  localparam logic [31:0] CTRL0_SET_MASK = 32'h0000_0010;
  localparam logic [31:0] FLAGS_RST = 32'h0000_0002;
  localparam int FLAGS_LOOSE_BITS = 10;
  localparam logic [15:0] CS_SEL_RST = 16'hf000;
  localparam logic [31:0] CS_BASE_RST = 32'hffff_0000;
  localparam logic [15:0] IP_RST = 16'hfff0;
  localparam logic [31:0] RESET_FETCH = 32'hffff_fff0;
  localparam int SEG_SHIFT = 4;
  // Numeric unit values after power-up and after the initialize command.
  localparam logic [15:0] FPU_CW_PWR = 16'h0040;
  localparam logic [15:0] FPU_CW_INIT = 16'h037f;
  localparam logic [15:0] FPU_SW_RST = 16'h0000;
  localparam logic [15:0] FPU_TAG_PWR = 16'h5555;
  localparam logic [15:0] FPU_TAG_INIT = 16'hffff;
  // Identification word; the value is arbitrary.
  localparam logic [31:0] IDENT_VALUE = 32'h0000_0a5c;
  // Cache, translation buffer and self-test geometry.
  localparam int CACHE_ENTRIES = 8;
  localparam int BUILT_IN_SELF_TEST_WORDS = 8;
  localparam logic [15:0] BUILT_IN_SELF_TEST_SEED = 16'hace1;
  typedef enum logic [2:0] {SEQ_IDLE, SEQ_INVAL, SEQ_BUILT_IN_SELF_TEST, SEQ_WAIT, SEQ_DONE} crisl_seq_t;
endpackage

// ---- rtl/crisl_built_in_self_test.sv ----
// Built-in self-test engine: writes a pseudo-random pattern to a small store and reads it back.
`timescale 1ns/1ps
module crisl_built_in_self_test
  import crisl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic faultInject,
  output logic done,
  output logic [31:0] result
);
  typedef struct packed {
    logic busy;
    logic checking;
    logic [2:0] idx;
    logic [15:0] lfsr;
    logic [BUILT_IN_SELF_TEST_WORDS-1:0][15:0] store;
    logic [7:0] errors;
    logic done;
  } crisl_built_in_self_test_t;
  crisl_built_in_self_test_t s, next_s;

  // Fill pass then check pass; each mismatching word bumps the error count.
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    if (start && !s.busy) begin
      next_s.busy = 1'b1;
      next_s.checking = 1'b0;
      next_s.idx = 3'h0;
      next_s.lfsr = BUILT_IN_SELF_TEST_SEED;
      next_s.errors = 8'h00;
    end else if (s.busy) begin
      next_s.lfsr = {s.lfsr[14:0], s.lfsr[15] ^ s.lfsr[13] ^ s.lfsr[12] ^ s.lfsr[10]};
      next_s.idx = s.idx + 3'h1;
      if (!s.checking) begin
        next_s.store[s.idx] = s.lfsr;
        if (s.idx == 3'h7) begin
          next_s.checking = 1'b1;
          next_s.lfsr = BUILT_IN_SELF_TEST_SEED;
        end
      end else begin
        if ((s.store[s.idx] ^ {15'h0000, faultInject}) != s.lfsr) begin
          next_s.errors = s.errors + 8'h01;
        end
        if (s.idx == 3'h7) begin
          next_s.busy = 1'b0;
          next_s.done = 1'b1;
        end
      end
    end
  end

  // State register.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign done = s.done;
  assign result = {24'h000000, s.errors};
endmodule

// ---- rtl/crisl_top.sv ----
// Reset and soft-initialization state loader for a 32-bit processor core, with APB register access.
`timescale 1ns/1ps
module crisl_top
  import crisl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hwResetReq,
  input wire logic softInitReq,
  input wire logic bistEnable,
  input wire logic bistFaultInject,
  input wire logic perfEvent,
  output logic coreRunning,
  output logic [31:0] fetchAddr
);
  typedef struct packed {
    crisl_seq_t seq;
    logic hardKind;
    logic [2:0] idx;
    logic prevHw;
    logic prevSoft;
    logic bistStart;
    logic [15:0] ldtSel;
    logic [15:0] ldtLimit;
    logic [31:0] ldtBase;
    logic [15:0] taskSel;
    logic [15:0] taskLimit;
    logic [31:0] taskBase;
    logic [7:0] ldtAttr;
    logic [7:0] taskAttr;
    logic [31:0] cycleCount;
    logic [31:0] perfCount;
    logic [31:0] perfSel;
    logic fixedEn;
    logic varEn;
    logic licEn;
    logic [31:0] msrScratch;
    logic [31:0] mchk;
    logic [31:0] flags;
    logic [31:0] ctrl0;
    logic [31:0] accum;
    logic [31:0] ident;
    logic [15:0] csSel;
    logic [31:0] csBase;
    logic [15:0] ip;
    logic [15:0] fpuCw;
    logic [15:0] fpuSw;
    logic [15:0] fpuTag;
    logic [31:0] packedReg;
    logic [CACHE_ENTRIES-1:0] dValid;
    logic [CACHE_ENTRIES-1:0] cValid;
    logic [CACHE_ENTRIES-1:0] tValid;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic running;
    logic [31:0] fetchAddr;
  } crisl_state_t;
  crisl_state_t s, next_s;

  logic bistDone;
  logic [31:0] bistResult;
  logic access;
  logic hardStart;
  logic softStart;
  logic csWrite;

  // Self-test engine, started only from the hard reset sequence.
  crisl_built_in_self_test u_built_in_self_test (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(s.bistStart),
    .faultInject(bistFaultInject),
    .done(bistDone),
    .result(bistResult)
  );

  // Request decode: rising edges of the request pins or control-register writes start a sequence.
  assign access = psel && penable && !s.pready;
  assign hardStart = (s.seq == SEQ_IDLE) && ((hwResetReq && !s.prevHw) ||
                     (access && pwrite && paddr == OFF_CTRL && pwdata[CTRL_HARD_RESET]));
  assign softStart = (s.seq == SEQ_IDLE) && !hardStart && ((softInitReq && !s.prevSoft) ||
                     (access && pwrite && paddr == OFF_CTRL && pwdata[CTRL_SOFT_INIT]));
  assign csWrite = (s.seq == SEQ_IDLE) && access && pwrite && paddr == OFF_CS_SEL;

  // Read multiplexer over the register map; unmapped offsets flag an error.
  function automatic logic [32:0] read_reg(input crisl_state_t r, input logic [7:0] a);
    logic [32:0] v;
    v = {1'b0, 32'h0000_0000};
    case (a)
      OFF_CTRL: v[31:0] = 32'h0000_0000;
      OFF_STATUS: v[31:0] = {27'h0000000, r.hardKind, r.running, r.seq};
      OFF_LDT_SELLIM: v[31:0] = {r.ldtLimit, r.ldtSel};
      OFF_LDT_BASE: v[31:0] = r.ldtBase;
      OFF_TASK_SELLIM: v[31:0] = {r.taskLimit, r.taskSel};
      OFF_TASK_BASE: v[31:0] = r.taskBase;
      OFF_DESC_ATTR: v[31:0] = {16'h0000, r.taskAttr, r.ldtAttr};
      OFF_CYCLE_COUNT: v[31:0] = r.cycleCount;
      OFF_PERF_COUNT: v[31:0] = r.perfCount;
      OFF_PERF_SEL: v[31:0] = r.perfSel;
      OFF_MTRR_CTRL: v[31:0] = {30'h00000000, r.varEn, r.fixedEn};
      OFF_LIC_CTRL: v[31:0] = {31'h00000000, r.licEn};
      OFF_MSR_SCRATCH: v[31:0] = r.msrScratch;
      OFF_MCHK: v[31:0] = r.mchk;
      OFF_FLAGS: v[31:0] = r.flags;
      OFF_CTRL0: v[31:0] = r.ctrl0;
      OFF_ACCUM: v[31:0] = r.accum;
      OFF_IDENT: v[31:0] = r.ident;
      OFF_CS_SEL: v[31:0] = {16'h0000, r.csSel};
      OFF_CS_BASE: v[31:0] = r.csBase;
      OFF_IP: v[31:0] = {16'h0000, r.ip};
      OFF_FETCH: v[31:0] = r.fetchAddr;
      OFF_FPU_CWSW: v[31:0] = {r.fpuSw, r.fpuCw};
      OFF_FPU_TAG: v[31:0] = {16'h0000, r.fpuTag};
      OFF_PACKED: v[31:0] = r.packedReg;
      OFF_CACHE_VALID: v[31:0] = {8'h00, r.tValid, r.cValid, r.dValid};
      OFF_CACHE_FILL: v[31:0] = 32'h0000_0000;
      default: v = {1'b1, 32'h0000_0000};
    endcase
    return v;
  endfunction

  // Next-state logic: bus slave, reset sequencer and free-running counters.
  always_comb begin
    logic [32:0] rd;
    rd = read_reg(s, paddr);
    next_s = s;
    next_s.prevHw = hwResetReq;
    next_s.prevSoft = softInitReq;
    next_s.bistStart = 1'b0;
    next_s.cycleCount = s.cycleCount + 32'h0000_0001;
    if (s.perfSel[0] && perfEvent) begin
      next_s.perfCount = s.perfCount + 32'h0000_0001;
    end
    next_s.pready = access;
    next_s.pslverr = access && rd[32];
    if (access && !pwrite) begin
      next_s.prdata = rd[31:0];
    end
    // Register writes are honoured only while the core runs.
    if (access && pwrite && s.seq == SEQ_IDLE) begin
      case (paddr)
        OFF_PERF_SEL: next_s.perfSel = pwdata;
        OFF_MTRR_CTRL: begin
          next_s.fixedEn = pwdata[0];
          next_s.varEn = pwdata[1];
        end
        OFF_LIC_CTRL: next_s.licEn = pwdata[0];
        OFF_MSR_SCRATCH: next_s.msrScratch = pwdata;
        OFF_MCHK: next_s.mchk = pwdata;
        OFF_FLAGS: next_s.flags = pwdata;
        OFF_CTRL0: next_s.ctrl0 = pwdata;
        OFF_CS_SEL: begin
          next_s.csSel = pwdata[15:0];
          next_s.csBase = {12'h000, pwdata[15:0], 4'h0};
        end
        OFF_FPU_CWSW: begin
          next_s.fpuCw = pwdata[15:0];
          next_s.fpuSw = pwdata[31:16];
        end
        OFF_FPU_TAG: next_s.fpuTag = pwdata[15:0];
        OFF_PACKED: next_s.packedReg = pwdata;
        OFF_CACHE_FILL: begin
          case (pwdata[4:3])
            2'h0: next_s.dValid[pwdata[2:0]] = 1'b1;
            2'h1: next_s.cValid[pwdata[2:0]] = 1'b1;
            default: next_s.tValid[pwdata[2:0]] = 1'b1;
          endcase
        end
        OFF_CTRL: begin
          if (pwdata[CTRL_FP_INIT]) begin
            next_s.fpuCw = FPU_CW_INIT;
            next_s.fpuSw = FPU_SW_RST;
            next_s.fpuTag = FPU_TAG_INIT;
          end
        end
        default: next_s.prdata = s.prdata;
      endcase
    end
    // Fetch address tracks the code base plus instruction pointer.
    next_s.fetchAddr = s.csBase + {16'h0000, s.ip};
    // Common loading for both kinds of reset.
    if (hardStart || softStart) begin
      next_s.seq = SEQ_INVAL;
      next_s.hardKind = hardStart;
      next_s.idx = 3'h0;
      next_s.running = 1'b0;
      next_s.ldtSel = DESC_SEL_RST;
      next_s.ldtBase = DESC_BASE_RST;
      next_s.ldtLimit = DESC_LIMIT_RST;
      next_s.ldtAttr = DESC_ATTR_RST;
      next_s.taskSel = DESC_SEL_RST;
      next_s.taskBase = DESC_BASE_RST;
      next_s.taskLimit = DESC_LIMIT_RST;
      next_s.taskAttr = DESC_ATTR_RST;
      next_s.ctrl0 = (s.ctrl0 & CTRL0_KEEP_MASK) | CTRL0_SET_MASK;
      next_s.flags = {s.flags[31:32-FLAGS_LOOSE_BITS], FLAGS_RST[31-FLAGS_LOOSE_BITS:0]};
      next_s.csSel = CS_SEL_RST;
      next_s.csBase = CS_BASE_RST;
      next_s.ip = IP_RST;
    end
    // Hard reset only; soft init leaves counters, range registers, controller and numeric state alone.
    if (hardStart) begin
      next_s.cycleCount = 32'h0000_0000;
      next_s.perfCount = 32'h0000_0000;
      next_s.perfSel = 32'h0000_0000;
      next_s.fixedEn = 1'b0;
      next_s.varEn = 1'b0;
      next_s.licEn = 1'b1;
      next_s.ident = IDENT_VALUE;
      next_s.accum = 32'h0000_0000;
      next_s.fpuCw = FPU_CW_PWR;
      next_s.fpuSw = FPU_SW_RST;
      next_s.fpuTag = FPU_TAG_PWR;
      next_s.packedReg = 32'h0000_0000;
    end
    // Sequencer: sweep invalidation, optional self-test, then release the core.
    case (s.seq)
      SEQ_IDLE: next_s.running = !(hardStart || softStart);
      SEQ_INVAL: begin
        next_s.dValid[s.idx] = 1'b0;
        next_s.cValid[s.idx] = 1'b0;
        next_s.tValid[s.idx] = 1'b0;
        next_s.idx = s.idx + 3'h1;
        if (s.idx == 3'(CACHE_ENTRIES - 1)) begin
          next_s.seq = (s.hardKind && bistEnable) ? SEQ_BUILT_IN_SELF_TEST : SEQ_DONE;
        end
      end
      SEQ_BUILT_IN_SELF_TEST: begin
        next_s.bistStart = 1'b1;
        next_s.seq = SEQ_WAIT;
      end
      SEQ_WAIT: begin
        if (bistDone) begin
          next_s.accum = bistResult;
          next_s.seq = SEQ_DONE;
        end
      end
      SEQ_DONE: begin
        next_s.seq = SEQ_IDLE;
        next_s.running = 1'b1;
      end
      default: next_s.seq = SEQ_IDLE;
    endcase
  end

  // State register; power-up starts a hard sequence from fixed values.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.seq <= SEQ_INVAL;
      s.hardKind <= 1'b1;
      s.ldtLimit <= DESC_LIMIT_RST;
      s.ldtAttr <= DESC_ATTR_RST;
      s.taskLimit <= DESC_LIMIT_RST;
      s.taskAttr <= DESC_ATTR_RST;
      s.licEn <= 1'b1;
      s.flags <= FLAGS_RST;
      s.ctrl0 <= CTRL0_PWR_RST;
      s.ident <= IDENT_VALUE;
      s.csSel <= CS_SEL_RST;
      s.csBase <= CS_BASE_RST;
      s.ip <= IP_RST;
      s.fpuCw <= FPU_CW_PWR;
      s.fpuTag <= FPU_TAG_PWR;
      s.fetchAddr <= RESET_FETCH;
      s.dValid <= '1;
      s.cValid <= '1;
      s.tValid <= '1;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign coreRunning = s.running;
  assign fetchAddr = s.fetchAddr;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  desc_load_a: assert property ((hardStart || softStart) |=> (s.ldtSel == DESC_SEL_RST &&
    s.ldtLimit == DESC_LIMIT_RST && s.taskBase == DESC_BASE_RST && s.ldtAttr == DESC_ATTR_RST))
    else $error("Descriptor pointers not loaded.");
  counter_keep_a: assert property (softStart |=> s.perfCount == $past(s.perfCount) +
    {31'h0, $past(s.perfSel[0] && perfEvent)}) else $error("Soft init disturbed perf counter.");
  cache_clear_a: assert property ((s.seq == SEQ_DONE) |->
    (s.dValid == '0 && s.cValid == '0 && s.tValid == '0)) else $error("Cache entry left valid.");
  range_off_a: assert property (hardStart |=> (!s.fixedEn && !s.varEn && s.licEn))
    else $error("Range registers or controller wrong after hard reset.");
  ctrl_reset_a: assert property ((hardStart || softStart) |=>
    s.ctrl0 == (($past(s.ctrl0) & CTRL0_KEEP_MASK) | CTRL0_SET_MASK)) else $error("Control register reset wrong.");
  built_in_self_test_hard_a: assert property ((s.seq == SEQ_BUILT_IN_SELF_TEST) |-> s.hardKind)
    else $error("Self-test started on soft init.");
  fpu_keep_a: assert property (softStart |=> (s.fpuTag == $past(s.fpuTag) &&
    s.packedReg == $past(s.packedReg))) else $error("Soft init disturbed numeric state.");
  first_fetch_a: assert property ((s.seq == SEQ_DONE && s.hardKind) |-> ##1
    (s.fetchAddr == RESET_FETCH && s.csSel == CS_SEL_RST)) else $error("First fetch address wrong.");
  cs_reload_a: assert property (csWrite |=> ##1 (s.csBase == {12'h000, $past(pwdata[15:0], 2), 4'h0} &&
    s.fetchAddr == s.csBase + {16'h0, $past(s.ip)})) else $error("Code base not selector times 16.");
  soft_ident_a: assert property (softStart |=> s.ident == $past(s.ident))
    else $error("Identification changed by soft init.");
endmodule

// ---- tb/crisl_platform_model.sv ----
// Platform reset source and boot ROM model that faces the reset state loader.
`timescale 1ns/1ps
module crisl_platform_model
  import crisl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hardCmd,
  input wire logic softCmd,
  input wire logic [31:0] fetchAddr,
  output logic hwResetReq,
  output logic softInitReq,
  output logic romHit
);
  logic [1:0] hardLeft;
  logic [1:0] softLeft;

  // Each command becomes a three-cycle pin pulse, so the device sees exactly one rising edge.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hardLeft <= 2'h0;
      softLeft <= 2'h0;
    end else begin
      hardLeft <= hardCmd ? 2'h3 : (hardLeft != 2'h0 ? hardLeft - 2'h1 : 2'h0);
      softLeft <= softCmd ? 2'h3 : (softLeft != 2'h0 ? softLeft - 2'h1 : 2'h0);
    end
  end
  assign hwResetReq = (hardLeft != 2'h0);
  assign softInitReq = (softLeft != 2'h0);

  // The boot ROM decodes the top 64 KiB, so it answers at the reset fetch address.
  // The firmware it holds issues no far transfer and enables no interrupt while it runs.
  assign romHit = (fetchAddr[31:16] == 16'hffff);
endmodule

// ---- tb/test_cpu_reset_init_state_loader.sv ----
// Self-checking testbench for the processor reset state loader.
`timescale 1ns/1ps
module test_cpu_reset_init_state_loader;
  import crisl_pkg::*;
  logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, hwResetReq, softInitReq;
  logic bistEnable, bistFaultInject, perfEvent, coreRunning, hardCmd, softCmd, romHit, lastErr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, fetchAddr, q, rnd, ctrl, c0, cyc0;
  logic [31:0] keep [8];
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [7:0] RA [17] = '{OFF_LDT_SELLIM, OFF_LDT_BASE, OFF_TASK_SELLIM, OFF_TASK_BASE, OFF_DESC_ATTR,
    OFF_PERF_COUNT, OFF_PERF_SEL, OFF_MTRR_CTRL, OFF_LIC_CTRL, OFF_CTRL0, OFF_ACCUM, OFF_IDENT, OFF_CS_SEL,
    OFF_CS_BASE, OFF_IP, OFF_FETCH, OFF_CACHE_VALID};
  logic [31:0] RV [17] = '{{DESC_LIMIT_RST, DESC_SEL_RST}, DESC_BASE_RST, {DESC_LIMIT_RST, DESC_SEL_RST},
    DESC_BASE_RST, {16'h0000, DESC_ATTR_RST, DESC_ATTR_RST}, 32'h0, 32'h0, 32'h0, 32'h1, CTRL0_PWR_RST, 32'h0,
    IDENT_VALUE, {16'h0000, CS_SEL_RST}, CS_BASE_RST, {16'h0000, IP_RST}, RESET_FETCH, 32'h0};
  logic [7:0] KA [8] = '{OFF_PERF_SEL, OFF_MTRR_CTRL, OFF_LIC_CTRL, OFF_MSR_SCRATCH, OFF_MCHK, OFF_FPU_CWSW,
    OFF_FPU_TAG, OFF_PACKED};
  logic [31:0] KM [8] = '{32'h1, 32'h3, 32'h1, 32'hffffffff, 32'hffffffff, 32'hffffffff, 32'hffff, 32'hffffffff};

  crisl_top u_dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hwResetReq(hwResetReq), .softInitReq(softInitReq), .bistEnable(bistEnable),
    .bistFaultInject(bistFaultInject), .perfEvent(perfEvent), .coreRunning(coreRunning), .fetchAddr(fetchAddr));

  crisl_platform_model u_plat (.ref_clk(ref_clk), .rst(rst), .hardCmd(hardCmd), .softCmd(softCmd),
    .fetchAddr(fetchAddr), .hwResetReq(hwResetReq), .softInitReq(softInitReq), .romHit(romHit));

  // Clock at 40 MHz.
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Galois shift register that supplies the random values.
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h0400_0007 : 32'h0);
  endfunction

  // Counts a comparison and reports a mismatch at once.
  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    total_checks++;
    if (seen !== want) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s seen %h want %h", $time, what, seen, want);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic report_and_stop();
    if (err_total == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One APB transfer: setup, access, then hold until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1);
    check({31'h0, pready}, 32'h1, "apb answer");
    check(n, 32'h2, "apb latency");
    q = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reads one register and compares it with the expected word.
  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    apb(1'b0, a, 32'h0);
    check(q, want, "register read");
  endtask

  // Lets a started sequence take hold, then waits a bounded time for the core to run again.
  task automatic wait_seq();
    int n;
    n = 0;
    repeat (5) @(posedge ref_clk);
    while (coreRunning !== 1'b1 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    check({31'h0, coreRunning}, 32'h1, "sequence end");
  endtask

  // Asks the platform model for a hard or soft request pulse.
  task automatic pulse(input logic hard);
    @(posedge ref_clk);
    hardCmd <= hard;
    softCmd <= ~hard;
    @(posedge ref_clk);
    hardCmd <= 1'b0;
    softCmd <= 1'b0;
    wait_seq();
  endtask

  // Cuts a hung run short.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      $display("CHECK FAILED at %0t: run timed out", $time);
      report_and_stop();
    end
  end

  // Main sequence.
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, hardCmd, softCmd, bistEnable, bistFaultInject, perfEvent} = 8'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    rnd = 32'h0766;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    wait_seq();
    for (int i = 0; i < 17; i++) rd(RA[i], RV[i]);
    check(fetchAddr, RESET_FETCH, "fetch port");
    check({31'h0, romHit}, 32'h1, "boot rom hit");
    apb(1'b0, 8'hfc, 32'h0);
    check({31'h0, lastErr}, 32'h1, "unmapped offset");
    // Firmware reads the identity, then sets the numeric flags for a present unit and initializes it.
    rd(OFF_IDENT, IDENT_VALUE);
    rnd = lfsr(rnd);
    ctrl = (rnd & 32'hffff_ffc0) | 32'h22;
    apb(1'b1, OFF_CTRL0, ctrl);
    rd(OFF_CTRL0, ctrl);
    apb(1'b1, OFF_CTRL, 32'h4);
    rd(OFF_FPU_CWSW, {FPU_SW_RST, FPU_CW_INIT});
    rd(OFF_FPU_TAG, {16'h0000, FPU_TAG_INIT});
    rnd = lfsr(rnd);
    apb(1'b1, OFF_FLAGS, rnd);
    apb(1'b0, OFF_FLAGS, 32'h0);
    check(q & 32'h003f_fffd, rnd & 32'h003f_fffd, "flags low bits");
    // Random state that a soft initialization must leave alone, plus filled cache entries.
    perfEvent <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      keep[i] = rnd & KM[i];
      apb(1'b1, KA[i], keep[i]);
      apb(1'b1, OFF_CACHE_FILL, {27'h0, rnd[12:8]});
    end
    apb(1'b0, OFF_CACHE_VALID, 32'h0);
    check({31'h0, q != 32'h0}, 32'h1, "cache filled");
    apb(1'b0, OFF_PERF_COUNT, 32'h0);
    c0 = q;
    apb(1'b0, OFF_CYCLE_COUNT, 32'h0);
    cyc0 = q;
    pulse(1'b0);
    for (int i = 0; i < 8; i++) rd(KA[i], keep[i]);
    for (int i = 0; i < 5; i++) rd(RA[i], RV[i]);
    for (int i = 12; i < 17; i++) rd(RA[i], RV[i]);
    rd(OFF_CTRL0, (ctrl & CTRL0_KEEP_MASK) | CTRL0_SET_MASK);
    rd(OFF_ACCUM, 32'h0);
    apb(1'b0, OFF_PERF_COUNT, 32'h0);
    check({31'h0, q >= c0}, 32'h1, "perf count kept");
    apb(1'b0, OFF_CYCLE_COUNT, 32'h0);
    check({31'h0, q > cyc0}, 32'h1, "cycle count kept");
    // A code selector reload switches the base to selector times sixteen.
    rnd = lfsr(rnd);
    apb(1'b1, OFF_CS_SEL, {16'h0000, rnd[15:0]});
    rd(OFF_CS_BASE, {12'h000, rnd[15:0], 4'h0});
    rd(OFF_FETCH, {12'h000, rnd[15:0], 4'h0} + {16'h0000, IP_RST});
    // Hard request with a failing self-test.
    bistEnable <= 1'b1;
    bistFaultInject <= 1'b1;
    pulse(1'b1);
    apb(1'b0, OFF_ACCUM, 32'h0);
    check(q, 32'(BUILT_IN_SELF_TEST_WORDS), "self-test fault seen");
    rd(OFF_MTRR_CTRL, 32'h0);
    rd(OFF_LIC_CTRL, 32'h1);
    rd(OFF_PERF_SEL, 32'h0);
    rd(OFF_CS_BASE, CS_BASE_RST);
    rd(OFF_CTRL0, (ctrl & CTRL0_KEEP_MASK) | CTRL0_SET_MASK);
    // Clean self-test through the register, then a soft init that must not run it.
    bistFaultInject <= 1'b0;
    apb(1'b1, OFF_CTRL, 32'h2);
    wait_seq();
    rd(OFF_ACCUM, 32'h0);
    bistFaultInject <= 1'b1;
    apb(1'b1, OFF_CTRL, 32'h1);
    wait_seq();
    rd(OFF_ACCUM, 32'h0);
    rd(OFF_CACHE_VALID, 32'h0);
    report_and_stop();
  end
endmodule
